// ==== pzm_cal_gen.sv ====
`include "pzm_cfg.svh"

module pzm_cal_gen
    import pzm_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic rtc_tick_in,
    output logic      cal_out
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       level;
    } pzm_cal_s;

    pzm_cal_s st_reg;
    pzm_cal_s st_next;

    // ***********************************************************
    // square wave from rtc ticks
    // ***********************************************************
    always_comb
    begin
        st_next = st_reg;
        if (rtc_tick_in)
        begin
            if (st_reg.cnt >= `PZM_CAL_HALF - `PZM_CAL_ONE)
            begin
                st_next.cnt   = '0;
                st_next.level = ~st_reg.level;
            end
            else
            begin
                st_next.cnt = st_reg.cnt + `PZM_CAL_ONE;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign cal_out = st_reg.level;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_CAL_STILL: assert property (
        !rtc_tick_in |=> $stable(cal_out))
        else $error("calibration output moved without a tick");

endmodule

// ==== pzm_cfg.svh ====
`ifndef PZM_CFG_SVH
`define PZM_CFG_SVH

// ***********************************************************
// pad and selector sizes
// ***********************************************************
`define PZM_NPINS      14
`define PZM_NSIG       29
`define PZM_SMALL_PINS 4'hA

// ***********************************************************
// per-pin function selector codes
// ***********************************************************
`define PZM_FN_GPIO    2'h0
`define PZM_FN_ALT1    2'h1
`define PZM_FN_ALT2    2'h2
`define PZM_FN_ALT3    2'h3

// ***********************************************************
// calibration output: rtc ticks per half period
// ***********************************************************
`define PZM_CAL_HALF   8'h01
`define PZM_CAL_ONE    8'h01

`endif

// ==== pzm_mux.sv ====
`include "pzm_cfg.svh"

module pzm_mux
    import pzm_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        pkg_twenty_in,
    input  wire logic        audio_en_in,
    input  wire pzm_sel_t    fn_sel_in,
    input  wire pzm_pins_t   gpio_out_in,
    input  wire pzm_pins_t   gpio_oe_in,
    output pzm_pins_t        gpio_in_out,
    input  wire pzm_drv_s    periph_drv_in,
    output pzm_sigvec_t      periph_rx_out,
    input  wire logic        rtc_tick_in,
    input  wire pzm_pins_t   pad_in,
    output pzm_pad_s         pad_drv_out
);

    // ***********************************************************
    // helpers
    // ***********************************************************
    function automatic pzm_sig_e pick3(
        input logic [1:0] fn,
        input pzm_sig_e   a1,
        input pzm_sig_e   a2,
        input pzm_sig_e   a3
    );
        case (fn)
            `PZM_FN_ALT1: pick3 = a1;
            `PZM_FN_ALT2: pick3 = a2;
            `PZM_FN_ALT3: pick3 = a3;
            default:      pick3 = SIG_NONE;
        endcase
    endfunction

    function automatic pzm_sig_e aud(
        input logic     en,
        input pzm_sig_e spi,
        input pzm_sig_e audio
    );
        aud = en ? audio : spi;
    endfunction

    // signal carried by one pin for one selector value
    function automatic pzm_sig_e pin_map(
        input logic [3:0] pin,
        input logic [1:0] fn,
        input logic       twenty,
        input logic       ae
    );
        pzm_sig_e s;
        s = SIG_NONE;
        case (pin)
            4'h0:
                s = pick3(fn, SIG_SWD_DATA,
                    aud(ae, SIG_SPI_B_MASTER_IN, SIG_AUDIO_SERIAL_IN),
                    SIG_UART_B_TRANSMIT);
            4'h1:
                s = pick3(fn, SIG_SWD_CLOCK,
                    aud(ae, SIG_SPI_B_MASTER_OUT, SIG_AUDIO_SERIAL_OUT),
                    SIG_UART_B_RECEIVE);
            4'h2:
                s = pick3(fn, SIG_TWOWIRE_B_CLOCK,
                    aud(ae, SIG_SPI_B_SERIAL_CLOCK, SIG_AUDIO_BIT_CLOCK),
                    SIG_RTC_CALIBRATION_OUT);
            4'h3:
                s = pick3(fn, SIG_TWOWIRE_B_DATA,
                    aud(ae, SIG_SPI_B_SELECT_ZERO, SIG_AUDIO_WORD_SELECT),
                    SIG_TIMER_A_PIN);
            4'h4:
                s = pick3(fn, SIG_SPI_A_MASTER_IN,
                    SIG_UART_A_TRANSMIT, SIG_NONE);
            4'h5:
                s = pick3(fn, SIG_SPI_A_MASTER_OUT,
                    SIG_UART_A_RECEIVE, SIG_NONE);
            4'h6:
                s = pick3(fn, SIG_SPI_A_SERIAL_CLOCK,
                    SIG_UART_A_CLEAR_TO_SEND, SIG_UART_B_TRANSMIT);
            4'h7:
                s = pick3(fn, SIG_SPI_A_SELECT_ZERO,
                    SIG_UART_A_REQUEST_TO_SEND, SIG_UART_B_RECEIVE);
            4'h8:
                s = pick3(fn, SIG_TWOWIRE_A_CLOCK,
                    SIG_SWD_DATA, SIG_NONE);
            4'h9:
                s = pick3(fn, SIG_TWOWIRE_A_DATA,
                    SIG_SWD_CLOCK, SIG_NONE);
            4'hA:
                s = pick3(fn,
                    aud(ae, SIG_SPI_B_MASTER_IN, SIG_AUDIO_SERIAL_IN),
                    SIG_UART_B_TRANSMIT, SIG_NONE);
            4'hB:
                s = pick3(fn,
                    aud(ae, SIG_SPI_B_MASTER_OUT, SIG_AUDIO_SERIAL_OUT),
                    SIG_UART_B_RECEIVE, SIG_NONE);
            4'hC:
                s = pick3(fn,
                    aud(ae, SIG_SPI_B_SERIAL_CLOCK, SIG_AUDIO_BIT_CLOCK),
                    SIG_UART_B_CLEAR_TO_SEND, SIG_NONE);
            4'hD:
                s = pick3(fn,
                    aud(ae, SIG_SPI_B_SELECT_ZERO, SIG_AUDIO_WORD_SELECT),
                    SIG_UART_B_REQUEST_TO_SEND, SIG_NONE);
            default:
                s = SIG_NONE;
        endcase
        if (!twenty && pin >= `PZM_SMALL_PINS)
        begin
            s = SIG_NONE;
        end
        pin_map = s;
    endfunction

    // ***********************************************************
    // state
    // ***********************************************************
    typedef struct packed {
        pzm_pad_s    pad;
        pzm_pins_t   gpio_in;
        pzm_sigvec_t rx;
    } pzm_mux_s;

    pzm_mux_s    st_reg;
    pzm_mux_s    st_next;
    pzm_sig_e    pin_sig [`PZM_NPINS];
    pzm_pins_t   pin_reach;
    logic        cal_level;
    pzm_sigvec_t drv_out;
    pzm_sigvec_t any_sel;

    // ***********************************************************
    // per-pin decode
    // ***********************************************************
    genvar g;
    generate
        for (g = 0; g < `PZM_NPINS; g++)
        begin : g_pin
            assign pin_sig[g] = pin_map(4'(g), fn_sel_in[g],
                                        pkg_twenty_in, audio_en_in);
            assign pin_reach[g] = pkg_twenty_in ||
                                  (4'(g) < `PZM_SMALL_PINS);
        end
    endgenerate

    pzm_cal_gen u_cal (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .rtc_tick_in (rtc_tick_in),
        .cal_out     (cal_level)
    );

    // calibration slot comes from the rtc divider, not the bus
    always_comb
    begin
        drv_out = periph_drv_in.out;
        drv_out[SIG_RTC_CALIBRATION_OUT] = cal_level;
    end

    // ***********************************************************
    // pad drive and input routing
    // ***********************************************************
    always_comb
    begin
        pzm_sig_e s;
        s = SIG_NONE;
        st_next = st_reg;
        any_sel = '0;
        st_next.gpio_in = pad_in;
        for (int i = 0; i < `PZM_NSIG; i++)
        begin
            st_next.rx[i] = pzm_idle_high(5'(i));
        end
        // descending so the lowest selected pin feeds the input
        for (int p = `PZM_NPINS - 1; p >= 0; p--)
        begin
            s = pin_sig[p];
            if (s != SIG_NONE)
            begin
                any_sel[s] = 1'b1;
                st_next.rx[s] = pad_in[p];
            end
        end
        st_next.rx[SIG_NONE] = 1'b0;
        for (int p = 0; p < `PZM_NPINS; p++)
        begin
            s = pin_sig[p];
            if (!pin_reach[p])
            begin
                st_next.pad.out[p] = 1'b0;
                st_next.pad.oe[p]  = 1'b0;
            end
            else if (fn_sel_in[p] == `PZM_FN_GPIO)
            begin
                st_next.pad.out[p] = gpio_out_in[p];
                st_next.pad.oe[p]  = gpio_oe_in[p];
            end
            else if (s == SIG_NONE)
            begin
                st_next.pad.out[p] = 1'b0;
                st_next.pad.oe[p]  = 1'b0;
            end
            else
            begin
                // same source bit for all copies
                st_next.pad.out[p] = drv_out[s];
                st_next.pad.oe[p]  = !pzm_in_only(s) &&
                    (s == SIG_RTC_CALIBRATION_OUT ||
                     periph_drv_in.oe[s]);
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            st_reg.pad     <= '0;
            st_reg.gpio_in <= '0;
            st_reg.rx      <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign pad_drv_out   = st_reg.pad;
    assign gpio_in_out   = st_reg.gpio_in;
    assign periph_rx_out = st_reg.rx;

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_cal_sel;
        fn_sel_in[2] == `PZM_FN_ALT3;
    endsequence

    sequence s_cal_held;
        s_cal_sel ##1 s_cal_sel;
    endsequence

    AST_B0_UART: assert property (
        fn_sel_in[0] == `PZM_FN_ALT3 |=>
        pad_drv_out.out[0] == $past(periph_drv_in.out[SIG_UART_B_TRANSMIT]))
        else $error("bit 0 third function not uart b transmit");

    AST_B1_RX: assert property (
        fn_sel_in[1] == `PZM_FN_ALT3 |=>
        !pad_drv_out.oe[1] &&
        periph_rx_out[SIG_UART_B_RECEIVE] == $past(pad_in[1]))
        else $error("bit 1 uart b receive not routed");

    AST_CAL_DRIVE: assert property (
        s_cal_held |-> pad_drv_out.oe[2] &&
        pad_drv_out.out[2] == $past(cal_level))
        else $error("calibration output not on bit 2");

    AST_TIMER: assert property (
        fn_sel_in[3] == `PZM_FN_ALT3 |=>
        pad_drv_out.oe[3] == $past(periph_drv_in.oe[SIG_TIMER_A_PIN]))
        else $error("bit 3 direction not from timer a");

    AST_EMPTY_FN: assert property (
        fn_sel_in[4] == `PZM_FN_ALT3 |=>
        !pad_drv_out.oe[4] && !pad_drv_out.out[4])
        else $error("unassigned function drove bit 4");

    AST_EMPTY_FN9: assert property (
        fn_sel_in[9] == `PZM_FN_ALT3 |=>
        !pad_drv_out.oe[9] && !pad_drv_out.out[9])
        else $error("unassigned function drove bit 9");

    AST_SMALL_PKG: assert property (
        !pkg_twenty_in |=> pad_drv_out.oe[13:10] == 4'h0)
        else $error("hidden bits driven on small package");

    AST_AUDIO: assert property (
        audio_en_in && pkg_twenty_in && fn_sel_in[12] == `PZM_FN_ALT1 |=>
        pad_drv_out.out[12] == $past(drv_out[SIG_AUDIO_BIT_CLOCK]))
        else $error("audio bit clock not on bit 12");

    AST_B10_UART: assert property (
        pkg_twenty_in && fn_sel_in[10] == `PZM_FN_ALT2 |=>
        pad_drv_out.out[10] == $past(drv_out[SIG_UART_B_TRANSMIT]))
        else $error("bit 10 not uart b transmit");

    AST_GPIO: assert property (
        fn_sel_in[5] == `PZM_FN_GPIO |=>
        pad_drv_out.oe[5] == $past(gpio_oe_in[5]) &&
        pad_drv_out.out[5] == $past(gpio_out_in[5]))
        else $error("gpio not passed to bit 5");

    AST_IDLE: assert property (
        !any_sel[SIG_TWOWIRE_A_CLOCK] && !any_sel[SIG_UART_A_TRANSMIT] |=>
        periph_rx_out[SIG_TWOWIRE_A_CLOCK] &&
        !periph_rx_out[SIG_UART_A_TRANSMIT])
        else $error("unselected input not at idle level");

    AST_IN_ONLY: assert property (
        fn_sel_in[1] == `PZM_FN_ALT1 |=> !pad_drv_out.oe[1])
        else $error("debug clock input drove bit 1");

    AST_PERIPH_OWN: assert property (
        fn_sel_in[4] == `PZM_FN_ALT2 |=>
        pad_drv_out.oe[4] == $past(periph_drv_in.oe[SIG_UART_A_TRANSMIT]) &&
        pad_drv_out.out[4] == $past(periph_drv_in.out[SIG_UART_A_TRANSMIT]))
        else $error("bit 4 not owned by uart a transmit");

    AST_B8_DEBUG: assert property (
        fn_sel_in[8] == `PZM_FN_ALT2 |=>
        pad_drv_out.out[8] == $past(drv_out[SIG_SWD_DATA]))
        else $error("bit 8 not debug data");

    AST_SMALL_RX: assert property (
        !pkg_twenty_in && fn_sel_in[0] != `PZM_FN_ALT2 |=>
        !periph_rx_out[SIG_SPI_B_MASTER_IN])
        else $error("hidden bit reached spi b master in");

endmodule

// ==== pzm_mux_tb.sv ====
`include "pzm_cfg.svh"

module pzm_mux_tb;
    import pzm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_in     = 1'h0;
    logic        rst_in     = 1'h1;
    logic        pkg_twenty = 1'h1;
    logic        audio_en   = 1'h0;
    logic        rtc_tick   = 1'h0;
    pzm_sel_t    fn_sel     = '0;
    pzm_pins_t   gpio_out   = '0;
    pzm_pins_t   gpio_oe    = '0;
    pzm_pins_t   ext        = '0;
    pzm_drv_s    drv        = '0;
    pzm_pins_t   gpio_in;
    pzm_pins_t   pad_in;
    pzm_sigvec_t rx;
    pzm_pad_s    pad;
    int          err_count  = 0;
    int          n_compared = 0;
    int          cyc        = 0;

    always #12.5 clk_in = ~clk_in;

    pzm_mux dut_u (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .pkg_twenty_in (pkg_twenty),
        .audio_en_in   (audio_en),
        .fn_sel_in     (fn_sel),
        .gpio_out_in   (gpio_out),
        .gpio_oe_in    (gpio_oe),
        .gpio_in_out   (gpio_in),
        .periph_drv_in (drv),
        .periph_rx_out (rx),
        .rtc_tick_in   (rtc_tick),
        .pad_in        (pad_in),
        .pad_drv_out   (pad)
    );

    pzm_pad_board board_u (
        .pad_drv_in (pad),
        .ext_in     (ext),
        .pad_out    (pad_in)
    );

    // ***********************************************************
    // helpers
    // ***********************************************************
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_count++;
            tally_and_finish;
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // input taken at one edge, pad at next, rx one edge later
    task automatic settle;
        repeat (3) @(posedge clk_in);
        #1;
    endtask

    // ***********************************************************
    // scenarios
    // ***********************************************************
    // kind: 0 drive only, 1 input only, 2 both
    task automatic mc(input int pin, input logic [1:0] fn,
                      input pzm_sig_e sig, input int kind);
        pzm_sel_t s;
        pzm_drv_s d;
        s = '0;
        s[pin] = fn;
        d = '0;
        if (kind != 1)
        begin
            d.out[sig] = 1'h1;
            d.oe[sig] = 1'h1;
            @(posedge clk_in);
            fn_sel <= s;
            gpio_oe <= '1;
            gpio_out <= '0;
            drv <= d;
            settle;
            chk($sformatf("pad %0d out", pin), 1'h1, pad.out[pin]);
            chk($sformatf("pad %0d oe", pin), 1'h1, pad.oe[pin]);
            d.out[sig] = 1'h0;
            @(posedge clk_in);
            drv <= d;
            gpio_out <= '1;
            settle;
            chk($sformatf("pad %0d low", pin), 1'h0, pad.out[pin]);
        end
        if (kind != 0)
        begin
            for (int v = 0; v < 2; v++)
            begin
                d = '0;
                d.out = v[0] ? '0 : '1;
                d.oe = (kind == 1) ? '1 : '0;
                @(posedge clk_in);
                fn_sel <= s;
                gpio_oe <= '1;
                gpio_out <= v[0] ? '0 : '1;
                drv <= d;
                ext <= v[0] ? '1 : '0;
                settle;
                chk($sformatf("rx %0d", sig), v[0], rx[sig]);
                if (kind == 1)
                    chk("input only oe", 1'h0, pad.oe[pin]);
            end
        end
    endtask

    task automatic gpio_chk;
        @(posedge clk_in);
        fn_sel <= '0;
        gpio_out <= 14'h2A5C;
        gpio_oe <= 14'h0FF0;
        ext <= 14'h1234;
        settle;
        chk("gpio oe", 14'h0FF0, pad.oe);
        chk("gpio out", 14'h0A50, pad.out & pad.oe);
        chk("gpio in", 14'h1A54, gpio_in);
    endtask

    task automatic idle_chk;
        pzm_sigvec_t e;
        pzm_sig_e    hi [15] = '{SIG_SWD_CLOCK, SIG_TWOWIRE_B_CLOCK,
            SIG_TWOWIRE_B_DATA, SIG_SPI_B_SERIAL_CLOCK,
            SIG_SPI_B_SELECT_ZERO, SIG_AUDIO_BIT_CLOCK,
            SIG_AUDIO_WORD_SELECT, SIG_UART_B_RECEIVE,
            SIG_UART_B_CLEAR_TO_SEND, SIG_SPI_A_SERIAL_CLOCK,
            SIG_SPI_A_SELECT_ZERO, SIG_UART_A_RECEIVE,
            SIG_UART_A_CLEAR_TO_SEND, SIG_TWOWIRE_A_CLOCK,
            SIG_TWOWIRE_A_DATA};
        e = '0;
        foreach (hi[i])
            e[hi[i]] = 1'h1;
        @(posedge clk_in);
        fn_sel <= '0;
        ext <= 14'h3FFF;
        settle;
        chk("idle rx", e, rx);
    endtask

    task automatic cal_chk;
        pzm_sel_t s;
        logic     lvl;
        s = '0;
        s[2] = 2'h3;
        @(posedge clk_in);
        fn_sel <= s;
        drv <= '0;
        gpio_oe <= '0;
        settle;
        chk("cal oe", 1'h1, pad.oe[2]);
        lvl = pad.out[2];
        repeat (2)
        begin
            lvl = ~lvl;
            @(posedge clk_in);
            rtc_tick <= 1'h1;
            @(posedge clk_in);
            rtc_tick <= 1'h0;
            settle;
            chk("cal level", lvl, pad.out[2]);
        end
        repeat (4) @(posedge clk_in);
        #1;
        chk("cal hold", lvl, pad.out[2]);
    endtask

    task automatic multi_chk;
        pzm_sel_t s;
        pzm_drv_s d;
        s = '0;
        s[0] = 2'h3;
        s[6] = 2'h3;
        s[10] = 2'h2;
        d = '0;
        d.out[SIG_UART_B_TRANSMIT] = 1'h1;
        d.oe[SIG_UART_B_TRANSMIT] = 1'h1;
        @(posedge clk_in);
        fn_sel <= s;
        drv <= d;
        gpio_oe <= '0;
        settle;
        chk("copies", 3'h7, {pad.out[10], pad.out[6], pad.out[0]});
        s = '0;
        s[1] = 2'h3;
        s[7] = 2'h3;
        s[11] = 2'h2;
        @(posedge clk_in);
        fn_sel <= s;
        drv <= '0;
        ext <= 14'h3FFD;
        settle;
        chk("low copy", 1'h0, rx[SIG_UART_B_RECEIVE]);
    endtask

    task automatic off_chk;
        pzm_sel_t s;
        s = '0;
        for (int p = 4; p < 14; p++)
            s[p] = (p == 6 || p == 7) ? 2'h0 : 2'h3;
        @(posedge clk_in);
        fn_sel <= s;
        drv <= '{out: '1, oe: '1};
        gpio_oe <= 14'h0000;
        settle;
        chk("unused oe", 8'h00, {pad.oe[13:8], pad.oe[5:4]});
        for (int p = 10; p < 14; p++)
            s[p] = 2'h1;
        @(posedge clk_in);
        pkg_twenty <= 1'h0;
        fn_sel <= s;
        gpio_oe <= 14'h3C00;
        settle;
        chk("small oe", 4'h0, pad.oe[13:10]);
        @(posedge clk_in);
        pkg_twenty <= 1'h1;
    endtask

    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'h0;
        gpio_chk;
        idle_chk;
        mc(0, 2'h1, SIG_SWD_DATA, 2);
        mc(0, 2'h2, SIG_SPI_B_MASTER_IN, 2);
        mc(0, 2'h3, SIG_UART_B_TRANSMIT, 0);
        mc(1, 2'h1, SIG_SWD_CLOCK, 1);
        mc(1, 2'h2, SIG_SPI_B_MASTER_OUT, 2);
        mc(1, 2'h3, SIG_UART_B_RECEIVE, 1);
        mc(2, 2'h1, SIG_TWOWIRE_B_CLOCK, 2);
        mc(2, 2'h2, SIG_SPI_B_SERIAL_CLOCK, 2);
        mc(3, 2'h1, SIG_TWOWIRE_B_DATA, 2);
        mc(3, 2'h2, SIG_SPI_B_SELECT_ZERO, 2);
        mc(3, 2'h3, SIG_TIMER_A_PIN, 2);
        mc(4, 2'h1, SIG_SPI_A_MASTER_IN, 2);
        mc(4, 2'h2, SIG_UART_A_TRANSMIT, 0);
        mc(5, 2'h1, SIG_SPI_A_MASTER_OUT, 2);
        mc(5, 2'h2, SIG_UART_A_RECEIVE, 1);
        mc(6, 2'h1, SIG_SPI_A_SERIAL_CLOCK, 2);
        mc(6, 2'h2, SIG_UART_A_CLEAR_TO_SEND, 1);
        mc(6, 2'h3, SIG_UART_B_TRANSMIT, 0);
        mc(7, 2'h1, SIG_SPI_A_SELECT_ZERO, 2);
        mc(7, 2'h2, SIG_UART_A_REQUEST_TO_SEND, 0);
        mc(7, 2'h3, SIG_UART_B_RECEIVE, 1);
        mc(8, 2'h1, SIG_TWOWIRE_A_CLOCK, 2);
        mc(8, 2'h2, SIG_SWD_DATA, 2);
        mc(9, 2'h1, SIG_TWOWIRE_A_DATA, 2);
        mc(9, 2'h2, SIG_SWD_CLOCK, 1);
        mc(10, 2'h1, SIG_SPI_B_MASTER_IN, 2);
        mc(10, 2'h2, SIG_UART_B_TRANSMIT, 0);
        mc(11, 2'h1, SIG_SPI_B_MASTER_OUT, 2);
        mc(11, 2'h2, SIG_UART_B_RECEIVE, 1);
        mc(12, 2'h1, SIG_SPI_B_SERIAL_CLOCK, 2);
        mc(12, 2'h2, SIG_UART_B_CLEAR_TO_SEND, 1);
        mc(13, 2'h1, SIG_SPI_B_SELECT_ZERO, 2);
        mc(13, 2'h2, SIG_UART_B_REQUEST_TO_SEND, 0);
        @(posedge clk_in);
        audio_en <= 1'h1;
        mc(0, 2'h2, SIG_AUDIO_SERIAL_IN, 2);
        mc(1, 2'h2, SIG_AUDIO_SERIAL_OUT, 2);
        mc(2, 2'h2, SIG_AUDIO_BIT_CLOCK, 2);
        mc(3, 2'h2, SIG_AUDIO_WORD_SELECT, 2);
        mc(12, 2'h1, SIG_AUDIO_BIT_CLOCK, 2);
        mc(13, 2'h1, SIG_AUDIO_WORD_SELECT, 2);
        @(posedge clk_in);
        audio_en <= 1'h0;
        cal_chk;
        multi_chk;
        off_chk;
        tally_and_finish;
    end
endmodule

// ==== pzm_pad_board.sv ====
`include "pzm_cfg.svh"

// ***********************************************************
// board side of the pads: pad level seen by the chip
// ***********************************************************
module pzm_pad_board
    import pzm_pkg::*;
(
    input  wire pzm_pad_s  pad_drv_in,
    input  wire pzm_pins_t ext_in,
    output pzm_pins_t      pad_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // chip drive wins where enabled, else the board's own level
    assign pad_out = (pad_drv_in.oe & pad_drv_in.out)
                   | (~pad_drv_in.oe & ext_in);
endmodule

// ==== pzm_pkg.sv ====
`include "pzm_cfg.svh"

package pzm_pkg;

    // ***********************************************************
    // peripheral signal identifiers, index into signal vectors
    // ***********************************************************
    typedef enum logic [4:0] {
        SIG_NONE,
        SIG_SWD_DATA,
        SIG_SWD_CLOCK,
        SIG_TWOWIRE_B_CLOCK,
        SIG_TWOWIRE_B_DATA,
        SIG_SPI_B_MASTER_IN,
        SIG_SPI_B_MASTER_OUT,
        SIG_SPI_B_SERIAL_CLOCK,
        SIG_SPI_B_SELECT_ZERO,
        SIG_AUDIO_SERIAL_IN,
        SIG_AUDIO_SERIAL_OUT,
        SIG_AUDIO_BIT_CLOCK,
        SIG_AUDIO_WORD_SELECT,
        SIG_UART_B_TRANSMIT,
        SIG_UART_B_RECEIVE,
        SIG_UART_B_CLEAR_TO_SEND,
        SIG_UART_B_REQUEST_TO_SEND,
        SIG_RTC_CALIBRATION_OUT,
        SIG_TIMER_A_PIN,
        SIG_SPI_A_MASTER_IN,
        SIG_SPI_A_MASTER_OUT,
        SIG_SPI_A_SERIAL_CLOCK,
        SIG_SPI_A_SELECT_ZERO,
        SIG_UART_A_TRANSMIT,
        SIG_UART_A_RECEIVE,
        SIG_UART_A_CLEAR_TO_SEND,
        SIG_UART_A_REQUEST_TO_SEND,
        SIG_TWOWIRE_A_CLOCK,
        SIG_TWOWIRE_A_DATA
    } pzm_sig_e;

    typedef logic [`PZM_NSIG-1:0]        pzm_sigvec_t;
    typedef logic [`PZM_NPINS-1:0]       pzm_pins_t;
    typedef logic [`PZM_NPINS-1:0][1:0]  pzm_sel_t;

    // per-signal drive from the peripheral instances
    typedef struct packed {
        pzm_sigvec_t out;
        pzm_sigvec_t oe;
    } pzm_drv_s;

    // drive toward the pads
    typedef struct packed {
        pzm_pins_t out;
        pzm_pins_t oe;
    } pzm_pad_s;

    // level seen by a peripheral input with no pin selected
    function automatic logic pzm_idle_high(input logic [4:0] s);
        case (pzm_sig_e'(s))
            SIG_SWD_CLOCK, SIG_TWOWIRE_A_CLOCK, SIG_TWOWIRE_A_DATA,
            SIG_TWOWIRE_B_CLOCK, SIG_TWOWIRE_B_DATA,
            SIG_SPI_A_SERIAL_CLOCK, SIG_SPI_A_SELECT_ZERO,
            SIG_SPI_B_SERIAL_CLOCK, SIG_SPI_B_SELECT_ZERO,
            SIG_AUDIO_BIT_CLOCK, SIG_AUDIO_WORD_SELECT,
            SIG_UART_A_RECEIVE, SIG_UART_B_RECEIVE,
            SIG_UART_A_CLEAR_TO_SEND, SIG_UART_B_CLEAR_TO_SEND:
                pzm_idle_high = 1'b1;
            default:
                pzm_idle_high = 1'b0;
        endcase
    endfunction

    // signals that never drive a pad
    function automatic logic pzm_in_only(input pzm_sig_e s);
        case (s)
            SIG_NONE, SIG_SWD_CLOCK, SIG_UART_A_RECEIVE,
            SIG_UART_B_RECEIVE, SIG_UART_A_CLEAR_TO_SEND,
            SIG_UART_B_CLEAR_TO_SEND:
                pzm_in_only = 1'b1;
            default:
                pzm_in_only = 1'b0;
        endcase
    endfunction

endpackage
